// file: common/wdt_pkg.sv
// package for the staged watchdog: register map, fields, timing
// assumes a 250 MHz core clock and a 32-bit Avalon-MM register bus
package wdt_pkg;

  localparam int CLK_HZ       = 250_000_000;
  localparam int UNIT_MS      = 100;
  localparam int UNIT_CYCLES  = (CLK_HZ / 1000) * UNIT_MS;
  localparam int TICK_W       = 25;
  localparam int TIME_W       = 16;

  localparam logic [15:0] MAX_TICKS = 16'hFFFF;
  localparam logic [15:0] MIN_TICKS = 16'h0000;
  localparam logic [31:0] UNIT_MS_VAL = 32'h0000_0064;
  localparam logic [31:0] MAX_MS_VAL  = 32'h0063_FF9C;
  localparam logic [31:0] MIN_MS_VAL  = 32'h0000_0000;

  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_STATUS  = 6'h04;
  localparam logic [5:0] OFS_DELAY   = 6'h08;
  localparam logic [5:0] OFS_EVENT   = 6'h0C;
  localparam logic [5:0] OFS_RESET   = 6'h10;
  localparam logic [5:0] OFS_EVTYPE  = 6'h14;
  localparam logic [5:0] OFS_IRQ_ST  = 6'h18;
  localparam logic [5:0] OFS_IRQ_MSK = 6'h1C;
  localparam logic [5:0] OFS_UNIT    = 6'h20;
  localparam logic [5:0] OFS_MAXT    = 6'h24;
  localparam logic [5:0] OFS_MINT    = 6'h28;

  localparam int CTRL_START = 0;
  localparam int CTRL_KICK  = 1;
  localparam int CTRL_STOP  = 2;

  localparam int ST_ERR   = 0;
  localparam int ST_EVENT = 1;
  localparam int ST_RESET = 2;
  localparam int ST_KICK_REFUSED = 3;

  localparam int ST_W = 4;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    EV_NONE   = 2'b00,
    EV_IRQ    = 2'b01,
    EV_SYSCTL = 2'b10,
    EV_PWRBTN = 2'b11
  } ev_type_t;

  typedef enum logic [1:0]
  {
    S_IDLE  = 2'b00,
    S_DELAY = 2'b01,
    S_EVENT = 2'b10,
    S_RESET = 2'b11
  } wdt_state_t;

  typedef struct packed
  {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } bus_req_t;

endpackage : wdt_pkg

// file: hw/staged_watchdog_timer.sv
// staged watchdog: delay, optional event, then board reset request
// assumes one 250 MHz clock and a host on a 32-bit Avalon-MM port

// Functional notes
// - delay times from zero to 6553.5 s in 100 ms steps are accepted.
// - a time outside the supported range is refused and flags an error.
// - the unit and the min and max times are readable in milliseconds.
// - at the end of the reset time the board reset process is started.
// - event type is none, interrupt, system control event or power button.
// - at the end of the event time the selected event is raised.
// - a variant without event support ignores event type and event time.
// - start is given after settings and then counting begins.
// - a kick after the delay phase restarts the timer from the delay.
// - stop halts the timer so that no event and no reset follow.
module staged_watchdog_timer #(
  parameter bit HAS_EVENT = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ,
  output logic             EV_IRQ_OUT,
  output logic             SYSTEM_CONTROL_EVENT,
  output logic             PWR_BUTTON,
  output logic             BOARD_RESET
);

  wdt_pkg::bus_req_t           req;
  logic                        wait_ff;
  logic [31:0]                 rdata_ff;
  logic [wdt_pkg::TIME_W-1:0]  delay_ff;
  logic [wdt_pkg::TIME_W-1:0]  event_ff;
  logic [wdt_pkg::TIME_W-1:0]  reset_ff;
  wdt_pkg::ev_type_t           evtype_ff;
  logic [wdt_pkg::ST_W-1:0]    irq_st_ff;
  logic [wdt_pkg::ST_W-1:0]    irq_msk_ff;
  logic [wdt_pkg::ST_W-1:0]    ev_set;
  logic [wdt_pkg::TICK_W-1:0]  div_ff;
  logic                        tick;
  logic [wdt_pkg::TIME_W-1:0]  cnt_ff;
  wdt_pkg::wdt_state_t         state_ff;
  wdt_pkg::wdt_state_t         nxt_state;
  logic [wdt_pkg::TIME_W-1:0]  nxt_cnt;
  logic                        wr;
  logic                        do_start;
  logic                        do_kick;
  logic                        do_stop;
  logic                        bad_time;
  logic                        event_on;
  logic                        stage_end;
  logic                        fire_event;
  logic                        fire_reset;
  logic                        kick_refused;
  logic                        irq_ff;
  logic                        ev_irq_ff;
  logic                        ev_sys_ff;
  logic                        ev_pwr_ff;
  logic                        brst_ff;

  assign req.read      = AVS_READ;
  assign req.write     = AVS_WRITE;
  assign req.address   = AVS_ADDRESS;
  assign req.writedata = AVS_WRITEDATA;

  // one wait state; a write lands at the answering edge
  assign wr = req.write && !wait_ff;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      wait_ff <= 1'b1;
    else
      wait_ff <= !((req.read || req.write) && wait_ff);
  end

  assign do_start = wr && req.address == wdt_pkg::OFS_CTRL &&
                    req.writedata[wdt_pkg::CTRL_START];
  assign do_kick  = wr && req.address == wdt_pkg::OFS_CTRL &&
                    req.writedata[wdt_pkg::CTRL_KICK];
  assign do_stop  = wr && req.address == wdt_pkg::OFS_CTRL &&
                    req.writedata[wdt_pkg::CTRL_STOP];

  // time fields wider than 16 bits are out of range
  assign bad_time = wr && (req.address == wdt_pkg::OFS_DELAY ||
                    req.address == wdt_pkg::OFS_EVENT ||
                    req.address == wdt_pkg::OFS_RESET) &&
                    req.writedata[31:16] != 16'h0000;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      delay_ff <= wdt_pkg::MIN_TICKS;
      event_ff <= wdt_pkg::MIN_TICKS;
      reset_ff <= wdt_pkg::MIN_TICKS;
    end
    else if (wr && !bad_time)
    begin
      if (req.address == wdt_pkg::OFS_DELAY)
        delay_ff <= req.writedata[15:0];
      if (req.address == wdt_pkg::OFS_EVENT && HAS_EVENT)
        event_ff <= req.writedata[15:0];
      if (req.address == wdt_pkg::OFS_RESET)
        reset_ff <= req.writedata[15:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      evtype_ff <= wdt_pkg::EV_NONE;
    else if (wr && req.address == wdt_pkg::OFS_EVTYPE && HAS_EVENT)
      evtype_ff <= wdt_pkg::ev_type_t'(req.writedata[1:0]);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_msk_ff <= '0;
    else if (wr && req.address == wdt_pkg::OFS_IRQ_MSK)
      irq_msk_ff <= req.writedata[wdt_pkg::ST_W-1:0];
  end

  // 100 ms tick, held at zero in idle and restarted on each kick
  assign tick = div_ff == wdt_pkg::TICK_W'(wdt_pkg::UNIT_CYCLES - 1);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      div_ff <= '0;
    else if (state_ff == wdt_pkg::S_IDLE || tick || do_kick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  assign event_on   = HAS_EVENT && evtype_ff != wdt_pkg::EV_NONE;
  assign stage_end  = cnt_ff == '0 && (tick || cnt_ff == '0);
  assign fire_event = state_ff == wdt_pkg::S_EVENT && stage_end &&
                      !do_stop && !do_kick;
  assign fire_reset = state_ff == wdt_pkg::S_RESET && stage_end &&
                      !do_stop && !do_kick;
  assign kick_refused = do_kick && (state_ff == wdt_pkg::S_IDLE ||
                        state_ff == wdt_pkg::S_DELAY);

  // stage sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (do_stop)
      nxt_state = wdt_pkg::S_IDLE;
    else if (do_start && state_ff == wdt_pkg::S_IDLE)
    begin
      nxt_state = wdt_pkg::S_DELAY;
      nxt_cnt   = delay_ff;
    end
    else if (do_kick && !kick_refused)
    begin
      nxt_state = wdt_pkg::S_DELAY;
      nxt_cnt   = delay_ff;
    end
    else
    begin
      unique case (state_ff)
        wdt_pkg::S_IDLE: nxt_cnt = '0;
        wdt_pkg::S_DELAY,
        wdt_pkg::S_EVENT,
        wdt_pkg::S_RESET:
        begin
          if (cnt_ff != '0 && tick)
            nxt_cnt = cnt_ff - 1'b1;
          else if (cnt_ff == '0)
          begin
            if (state_ff == wdt_pkg::S_DELAY && event_on)
            begin
              nxt_state = wdt_pkg::S_EVENT;
              nxt_cnt   = event_ff;
            end
            else if (state_ff != wdt_pkg::S_RESET)
            begin
              nxt_state = wdt_pkg::S_RESET;
              nxt_cnt   = reset_ff;
            end
            else
              nxt_state = wdt_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_ff <= wdt_pkg::S_IDLE;
      cnt_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // event and board reset pulses
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ev_irq_ff <= 1'b0;
      ev_sys_ff <= 1'b0;
      ev_pwr_ff <= 1'b0;
      brst_ff   <= 1'b0;
    end
    else
    begin
      ev_irq_ff <= fire_event && evtype_ff == wdt_pkg::EV_IRQ;
      ev_sys_ff <= fire_event && evtype_ff == wdt_pkg::EV_SYSCTL;
      ev_pwr_ff <= fire_event && evtype_ff == wdt_pkg::EV_PWRBTN;
      brst_ff   <= fire_reset;
    end
  end

  // sticky status, write one to clear, set wins
  assign ev_set[wdt_pkg::ST_ERR]          = bad_time;
  assign ev_set[wdt_pkg::ST_EVENT]        = fire_event;
  assign ev_set[wdt_pkg::ST_RESET]        = fire_reset;
  assign ev_set[wdt_pkg::ST_KICK_REFUSED] = kick_refused;

  generate
    for (genvar i = 0; i < wdt_pkg::ST_W; i++)
    begin : g_st
      always_ff @(posedge CLK or negedge RESET_N)
      begin
        if (!RESET_N)
          irq_st_ff[i] <= 1'b0;
        else if (ev_set[i])
          irq_st_ff[i] <= 1'b1;
        else if (wr && req.address == wdt_pkg::OFS_IRQ_ST &&
                 req.writedata[i])
          irq_st_ff[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_st_ff & irq_msk_ff);
  end

  // read mux
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rdata_ff <= '0;
    else if (req.read && wait_ff)
    begin
      unique case (req.address)
        wdt_pkg::OFS_CTRL:    rdata_ff <= '0;
        wdt_pkg::OFS_STATUS:  rdata_ff <= {28'h0, 1'b0, HAS_EVENT,
                                           state_ff};
        wdt_pkg::OFS_DELAY:   rdata_ff <= {16'h0, delay_ff};
        wdt_pkg::OFS_EVENT:   rdata_ff <= {16'h0, event_ff};
        wdt_pkg::OFS_RESET:   rdata_ff <= {16'h0, reset_ff};
        wdt_pkg::OFS_EVTYPE:  rdata_ff <= {30'h0, evtype_ff};
        wdt_pkg::OFS_IRQ_ST:  rdata_ff <= {28'h0, irq_st_ff};
        wdt_pkg::OFS_IRQ_MSK: rdata_ff <= {28'h0, irq_msk_ff};
        wdt_pkg::OFS_UNIT:    rdata_ff <= wdt_pkg::UNIT_MS_VAL;
        wdt_pkg::OFS_MAXT:    rdata_ff <= wdt_pkg::MAX_MS_VAL;
        wdt_pkg::OFS_MINT:    rdata_ff <= wdt_pkg::MIN_MS_VAL;
        default:              rdata_ff <= wdt_pkg::RD_UNMAPPED;
      endcase
    end
  end

  assign AVS_READDATA         = rdata_ff;
  assign AVS_WAITREQUEST      = wait_ff;
  assign IRQ                  = irq_ff;
  assign EV_IRQ_OUT           = ev_irq_ff;
  assign SYSTEM_CONTROL_EVENT = ev_sys_ff;
  assign PWR_BUTTON           = ev_pwr_ff;
  assign BOARD_RESET          = brst_ff;

  property p_stop_halts;
    @(posedge CLK) disable iff (!RESET_N)
    do_stop |=> state_ff == wdt_pkg::S_IDLE;
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("stop did not halt timer");

  property p_reset_pulse;
    @(posedge CLK) disable iff (!RESET_N)
    fire_reset |=> BOARD_RESET ##1 !BOARD_RESET;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("board reset pulse wrong");

  property p_event_type;
    @(posedge CLK) disable iff (!RESET_N)
    fire_event && evtype_ff == wdt_pkg::EV_SYSCTL
      |=> SYSTEM_CONTROL_EVENT && !EV_IRQ_OUT && !PWR_BUTTON;
  endproperty
  a_event_type: assert property (p_event_type)
    else $error("wrong event raised");

  property p_no_event_none;
    @(posedge CLK) disable iff (!RESET_N)
    evtype_ff == wdt_pkg::EV_NONE |-> state_ff != wdt_pkg::S_EVENT ||
      $past(evtype_ff) != wdt_pkg::EV_NONE;
  endproperty
  a_no_event_none: assert property (p_no_event_none)
    else $error("event stage without type");

  property p_kick_restart;
    @(posedge CLK) disable iff (!RESET_N)
    do_kick && !kick_refused && !do_stop
      |=> state_ff == wdt_pkg::S_DELAY && cnt_ff == delay_ff;
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("kick did not restart delay");

  property p_bad_refused;
    @(posedge CLK) disable iff (!RESET_N)
    bad_time |=> irq_st_ff[wdt_pkg::ST_ERR] && $stable(delay_ff);
  endproperty
  a_bad_refused: assert property (p_bad_refused)
    else $error("bad time accepted");

  property p_start;
    @(posedge CLK) disable iff (!RESET_N)
    do_start && !do_stop && state_ff == wdt_pkg::S_IDLE
      |=> state_ff == wdt_pkg::S_DELAY;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not begin delay");

  property p_delay_to_event;
    @(posedge CLK) disable iff (!RESET_N)
    state_ff == wdt_pkg::S_DELAY && cnt_ff == '0 && event_on &&
      !do_stop && !do_kick |=> state_ff == wdt_pkg::S_EVENT;
  endproperty
  a_delay_to_event: assert property (p_delay_to_event)
    else $error("delay did not lead to event stage");

endmodule : staged_watchdog_timer

// file: verification/board_side_model.sv
// board side: counts event and reset pulses from the watchdog
// assumes one-cycle pulses, index 0 irq, 1 sysctl, 2 pwrbtn, 3 reset
module board_side_model (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [3:0]      pulse,
  output logic      [3:0][7:0] cnt_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else
      for (int i = 0; i < 4; i++)
        cnt_ff[i] <= cnt_ff[i] + 8'(pulse[i]);
  end
endmodule : board_side_model

// file: verification/staged_watchdog_timer_tb.sv
// testbench for the staged watchdog over its Avalon-MM port
// assumes the 250 MHz clock and the 100 ms tick, so only zero times expire
module staged_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic            CLK = 1'b0;
  logic            RESET_N = 1'b0;
  logic [5:0]      AVS_ADDRESS = 6'h00;
  logic            AVS_READ = 1'b0;
  logic            AVS_WRITE = 1'b0;
  logic [31:0]     AVS_WRITEDATA = 32'h0000_0000;
  logic [31:0]     AVS_READDATA;
  logic            AVS_WAITREQUEST;
  logic            IRQ;
  logic [3:0]      pulse;
  logic [3:0][7:0] cnt;
  int              failures = 0;
  int              cmp_count = 0;
  logic [31:0]     rd_ne;
  logic [31:0]     q_ne;

  always #2 CLK = ~CLK;

  staged_watchdog_timer u_dut (
    .CLK(CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
    .EV_IRQ_OUT(pulse[0]), .SYSTEM_CONTROL_EVENT(pulse[1]),
    .PWR_BUTTON(pulse[2]), .BOARD_RESET(pulse[3])
  );

  board_side_model u_board (.clk(CLK), .rst_n(RESET_N), .pulse(pulse),
    .cnt_ff(cnt));

  // variant without event support, sharing the bus
  staged_watchdog_timer #(.HAS_EVENT(1'b0)) u_dut_ne (
    .CLK(CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(rd_ne),
    .AVS_WAITREQUEST(), .IRQ(), .EV_IRQ_OUT(), .SYSTEM_CONTROL_EVENT(),
    .PWR_BUTTON(), .BOARD_RESET()
  );

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one access; times are whole unit counts
  task automatic bus(input logic rd, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    q = AVS_READDATA;
    q_ne = rd_ne;
    if (AVS_WAITREQUEST !== 1'b0)
      failures++;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd_chk

  task automatic t_info;
    rd_chk(wdt_pkg::OFS_UNIT, 32'h0000_0064);
    rd_chk(wdt_pkg::OFS_MAXT, 32'h0063_FF9C);
    rd_chk(wdt_pkg::OFS_MINT, 32'h0000_0000);
    rd_chk(6'h3C, 32'h0000_0000);
  endtask : t_info

  task automatic t_range;
    logic [5:0] a [3];
    a = '{wdt_pkg::OFS_DELAY, wdt_pkg::OFS_EVENT, wdt_pkg::OFS_RESET};
    foreach (a[i])
    begin
      wr(a[i], 32'h0000_FFFF);
      wr(a[i], 32'h0001_0000);
      rd_chk(a[i], 32'h0000_FFFF);
      rd_chk(wdt_pkg::OFS_IRQ_ST, 32'h0000_0001);
      wr(wdt_pkg::OFS_IRQ_ST, 32'h0000_000F);
    end
  endtask : t_range

  task automatic t_stop;
    wr(wdt_pkg::OFS_DELAY, 32'h0000_FFFF);
    wr(wdt_pkg::OFS_EVTYPE, 32'h0000_0001);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0005);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0002);
    rd_chk(wdt_pkg::OFS_IRQ_ST, 32'h0000_0008);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0004);
    rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0004);
    wr(wdt_pkg::OFS_IRQ_ST, 32'h0000_000F);
    wr(wdt_pkg::OFS_DELAY, 32'h0000_0000);
    wr(wdt_pkg::OFS_EVENT, 32'h0000_0001);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0006);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0002);
    rd_chk(wdt_pkg::OFS_IRQ_ST, 32'h0000_0000);
    rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0006);
    wr(wdt_pkg::OFS_CTRL, 32'h0000_0004);
    rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0004);
  endtask : t_stop

  task automatic t_events;
    logic [3:0][7:0] c0;
    int              n;
    for (int t = 0; t < 4; t++)
    begin
      wr(wdt_pkg::OFS_DELAY, 32'h0000_0000);
      wr(wdt_pkg::OFS_EVENT, 32'h0000_0000);
      wr(wdt_pkg::OFS_RESET, 32'h0000_0000);
      wr(wdt_pkg::OFS_EVTYPE, 32'(t));
      c0 = cnt;
      wr(wdt_pkg::OFS_CTRL, 32'h0000_0001);
      n = 0;
      while (cnt[3] === c0[3] && n < 100)
      begin
        @(posedge CLK);
        n++;
      end
      repeat (3) @(posedge CLK);
      for (int i = 0; i < 3; i++)
        chk(32'(cnt[i] - c0[i]), 32'(t == i + 1));
      chk(32'(cnt[3] - c0[3]), 32'h0000_0001);
      rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0004);
    end
  endtask : t_events

  task automatic t_irq;
    rd_chk(wdt_pkg::OFS_IRQ_ST, 32'h0000_0006);
    wr(wdt_pkg::OFS_IRQ_MSK, 32'h0000_0000);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h0000_0000);
    wr(wdt_pkg::OFS_IRQ_MSK, 32'h0000_0002);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h0000_0001);
    wr(wdt_pkg::OFS_IRQ_ST, 32'h0000_0002);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h0000_0000);
    rd_chk(wdt_pkg::OFS_IRQ_ST, 32'h0000_0004);
  endtask : t_irq

  // event settings land in the full part and vanish in the variant
  task automatic t_variant;
    wr(wdt_pkg::OFS_EVTYPE, 32'h0000_0003);
    wr(wdt_pkg::OFS_EVENT, 32'h0000_0007);
    rd_chk(wdt_pkg::OFS_EVENT, 32'h0000_0007);
    chk(q_ne, 32'h0000_0000);
    rd_chk(wdt_pkg::OFS_EVTYPE, 32'h0000_0003);
    chk(q_ne, 32'h0000_0000);
    rd_chk(wdt_pkg::OFS_STATUS, 32'h0000_0004);
    chk(q_ne, 32'h0000_0000);
  endtask : t_variant

  initial
  begin
    #60000;
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    t_info();
    t_range();
    t_stop();
    t_events();
    t_irq();
    t_variant();
    wrap_up();
  end
endmodule : staged_watchdog_timer_tb
